//--- shared/port2_defs.svh
// Purpose: Address map, field positions, reset values of the port 2 block
// Assumes: 16-bit CPU register addresses, 8-bit register data
// Notes: Definitions only
`ifndef PORT2_DEFS_SVH
`define PORT2_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define PORT_DATA_ADDR 16'hFFD5
`define PORT_DIR_ADDR 16'hFFE5
`define PIN_MODE_B_ADDR 16'hFFFF

// ****************************************************************
// Reset and read values
// ****************************************************************
`define PORT_DATA_RST 8'h00
`define PORT_DIR_RST 8'h00
`define PORT_DIR_READ 8'hFF
`define PIN_MODE_B_RST 8'hF8
`define PIN_MODE_B_ONES 8'hF8
`define PIN_MODE_B_WMASK 8'h05
`define UNMAPPED_READ 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define TX_SEL_BIT 2
`define OPEN_DRAIN_BIT 0
`define SCK_PIN 0
`define RX_PIN 1
`define TX_PIN 2

`endif

//--- shared/port2_pkg.sv
// Purpose: Types shared by the port 2 block
// Assumes: Nothing
// Notes: Constants live in port2_defs.svh
package port2_pkg;

    // Operating mode reported by the power controller
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'h0,
        PM_SUBACTIVE = 3'h1,
        PM_SLEEP = 3'h2,
        PM_SUBSLEEP = 3'h3,
        PM_WATCH = 3'h4,
        PM_STANDBY = 3'h5
    } powerMode_t;

    // Pin driver state
    typedef enum logic [2:0] {
        ST_HIZ = 3'h1,
        ST_RUN = 3'h2,
        ST_HOLD = 3'h4
    } portState_t;

    // Function of the shared clock pin
    typedef enum logic [3:0] {
        FN_GPIO_IN = 4'h1,
        FN_GPIO_OUT = 4'h2,
        FN_SER_OUT = 4'h4,
        FN_SER_IN = 4'h8
    } pinFunc_t;

endpackage

//--- shared/pin_select_if.sv
// Purpose: Carries pin selection inputs and mux results between modules
// Assumes: Single clock domain
// Notes: Purely combinational signals
`timescale 1ns/1ps
interface pin_select_if;
    logic [7:0] dirBits;
    logic [7:0] dataBits;
    logic txSelect;
    logic rxOn;
    logic clkSelHigh;
    logic clkSelLow;
    logic syncMode;
    logic txData;
    logic sckOut;
    logic [7:0] nextOut;
    logic [7:0] nextOe;
    port2_pkg::pinFunc_t sckFunc;

    modport ctrl (
        output dirBits, dataBits, txSelect, rxOn, clkSelHigh, clkSelLow,
        output syncMode, txData, sckOut,
        input nextOut, nextOe, sckFunc
    );
    modport mux (
        input dirBits, dataBits, txSelect, rxOn, clkSelHigh, clkSelLow,
        input syncMode, txData, sckOut,
        output nextOut, nextOe, sckFunc
    );
endinterface

//--- logic/port2_pin_mux.sv
// Purpose: Chooses per-pin drive value and enable for port 2
// Assumes: Selection bits are stable levels from the serial unit and the pin mode register
// Notes: Combinational only
`timescale 1ns/1ps
`include "port2_defs.svh"
module port2_pin_mux (
    pin_select_if.mux sel
);

    // ****************************************************************
    // Pin function selection
    // ****************************************************************
    always_comb begin
        sel.nextOut = sel.dataBits;
        sel.nextOe = sel.dirBits;
        // Transmit pin owned by serial unit
        if (sel.txSelect) begin
            sel.nextOut[`TX_PIN] = sel.txData;
            sel.nextOe[`TX_PIN] = 1'b1;
        end
        // Receive pin is input only while enabled
        if (sel.rxOn) begin
            sel.nextOut[`RX_PIN] = 1'b0;
            sel.nextOe[`RX_PIN] = 1'b0;
        end
        // Serial clock pin
        if (sel.clkSelHigh) begin
            sel.sckFunc = port2_pkg::FN_SER_IN;
        end else if (sel.clkSelLow || sel.syncMode) begin
            sel.sckFunc = port2_pkg::FN_SER_OUT;
        end else if (sel.dirBits[`SCK_PIN]) begin
            sel.sckFunc = port2_pkg::FN_GPIO_OUT;
        end else begin
            sel.sckFunc = port2_pkg::FN_GPIO_IN;
        end
        case (sel.sckFunc)
            port2_pkg::FN_SER_IN: begin
                sel.nextOut[`SCK_PIN] = 1'b0;
                sel.nextOe[`SCK_PIN] = 1'b0;
            end
            port2_pkg::FN_SER_OUT: begin
                sel.nextOut[`SCK_PIN] = sel.sckOut;
                sel.nextOe[`SCK_PIN] = 1'b1;
            end
            default: begin
                sel.nextOut[`SCK_PIN] = sel.dataBits[`SCK_PIN];
                sel.nextOe[`SCK_PIN] = sel.dirBits[`SCK_PIN];
            end
        endcase
    end

endmodule // port2_pin_mux

//--- logic/port2_gpio.sv
// Purpose: Eight-bit port 2 with data, direction and pin mode registers
// Assumes: Pins and power mode synchronous to sys_clk; serial unit supplies
//          its enable bits and transmit/clock levels
// Notes: Pin drivers follow the power mode with two cycles of latency
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "port2_defs.svh"
module port2_gpio (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    input wire port2_pkg::powerMode_t powerMode,
    input wire logic rxOnBit,
    input wire logic clockSelectHigh,
    input wire logic clockSelectLow,
    input wire logic syncMode,
    input wire logic txData,
    input wire logic sckOut,
    output logic txSelect,
    output logic rxData,
    output logic sckIn
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic regHit(input logic [15:0] addr, input logic [15:0] target);
        regHit = (addr == target);
    endfunction

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] portData_q;
    logic [7:0] portData_d;
    logic [7:0] portDir_q;
    logic [7:0] portDir_d;
    logic [7:0] pinModeB_q;
    logic [7:0] pinModeB_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;

    always_comb begin
        portData_d = portData_q;
        portDir_d = portDir_q;
        pinModeB_d = pinModeB_q;
        rdData_d = `UNMAPPED_READ;
        if (regWrite) begin
            if (regHit(regAddr, `PORT_DATA_ADDR)) begin
                portData_d = regWrData;
            end
            if (regHit(regAddr, `PORT_DIR_ADDR)) begin
                portDir_d = regWrData;
            end
            if (regHit(regAddr, `PIN_MODE_B_ADDR)) begin
                pinModeB_d = `PIN_MODE_B_ONES | (regWrData & `PIN_MODE_B_WMASK);
            end
        end
        if (regRead) begin
            if (regHit(regAddr, `PORT_DATA_ADDR)) begin
                // Output pins return latch, inputs the pin
                rdData_d = (portData_q & portDir_q) | (pinIn & ~portDir_q);
            end else if (regHit(regAddr, `PORT_DIR_ADDR)) begin
                rdData_d = `PORT_DIR_READ;
            end else if (regHit(regAddr, `PIN_MODE_B_ADDR)) begin
                rdData_d = pinModeB_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            portData_q <= `PORT_DATA_RST;
            portDir_q <= `PORT_DIR_RST;
            pinModeB_q <= `PIN_MODE_B_RST;
            rdData_q <= `UNMAPPED_READ;
        end else begin
            portData_q <= portData_d;
            portDir_q <= portDir_d;
            pinModeB_q <= pinModeB_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    assign txSelect = pinModeB_q[`TX_SEL_BIT];

    // ****************************************************************
    // Pin function mux
    // ****************************************************************
    pin_select_if sel ();

    assign sel.dirBits = portDir_q;
    assign sel.dataBits = portData_q;
    assign sel.txSelect = pinModeB_q[`TX_SEL_BIT];
    assign sel.rxOn = rxOnBit;
    assign sel.clkSelHigh = clockSelectHigh;
    assign sel.clkSelLow = clockSelectLow;
    assign sel.syncMode = syncMode;
    assign sel.txData = txData;
    assign sel.sckOut = sckOut;

    port2_pin_mux pinMux (
        .sel(sel)
    );

    // ****************************************************************
    // Power mode state
    // ****************************************************************
    port2_pkg::portState_t portState_q;
    port2_pkg::portState_t portState_d;

    always_comb begin
        case (powerMode)
            port2_pkg::PM_ACTIVE,
            port2_pkg::PM_SUBACTIVE: begin
                portState_d = port2_pkg::ST_RUN;
            end
            port2_pkg::PM_SLEEP,
            port2_pkg::PM_SUBSLEEP,
            port2_pkg::PM_WATCH: begin
                portState_d = port2_pkg::ST_HOLD;
            end
            default: begin
                portState_d = port2_pkg::ST_HIZ;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            portState_q <= port2_pkg::ST_HIZ;
        end else begin
            portState_q <= portState_d;
        end
    end

    // ****************************************************************
    // Pin drivers and serial input capture
    // ****************************************************************
    logic [7:0] pinOut_q;
    logic [7:0] pinOut_d;
    logic [7:0] pinOe_q;
    logic [7:0] pinOe_d;
    logic rxData_q;
    logic rxData_d;
    logic sckIn_q;
    logic sckIn_d;

    always_comb begin
        case (portState_q)
            port2_pkg::ST_RUN: begin
                pinOut_d = sel.nextOut;
                pinOe_d = sel.nextOe;
            end
            port2_pkg::ST_HOLD: begin
                pinOut_d = pinOut_q;
                pinOe_d = pinOe_q;
            end
            default: begin
                pinOut_d = 8'h00;
                pinOe_d = 8'h00;
            end
        endcase
        rxData_d = pinIn[`RX_PIN];
        sckIn_d = pinIn[`SCK_PIN];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pinOut_q <= 8'h00;
            pinOe_q <= 8'h00;
            rxData_q <= 1'b0;
            sckIn_q <= 1'b0;
        end else begin
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
            rxData_q <= rxData_d;
            sckIn_q <= sckIn_d;
        end
    end

    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign rxData = rxData_q;
    assign sckIn = sckIn_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    data_write_store_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        regWrite && regAddr == `PORT_DATA_ADDR |=> portData_q == $past(regWrData)
    ) else $error("data register did not store write");

    data_reset_zero_a: assert property (
        @(posedge sys_clk)
        !rst_n |=> portData_q == `PORT_DATA_RST
    ) else $error("data register not cleared by reset");

    read_out_latch_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        regRead && regAddr == `PORT_DATA_ADDR
        |=> (regRdData & $past(portDir_q)) == ($past(portData_q) & $past(portDir_q))
    ) else $error("output pin read did not return latch");

    read_in_pin_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        regRead && regAddr == `PORT_DATA_ADDR
        |=> (regRdData & ~$past(portDir_q)) == ($past(pinIn) & ~$past(portDir_q))
    ) else $error("input pin read did not return pin level");

    gpio_drive_follow_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN
        |=> pinOe[7:3] == $past(portDir_q[7:3]) && pinOut[7:3] == $past(portData_q[7:3])
    ) else $error("general pin drive does not follow registers");

    dir_read_ones_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        regRead && regAddr == `PORT_DIR_ADDR |=> regRdData == `PORT_DIR_READ
    ) else $error("direction read not all ones");

    dir_reset_input_a: assert property (
        @(posedge sys_clk)
        !rst_n |=> portDir_q == `PORT_DIR_RST && pinOe == 8'h00
    ) else $error("pins not inputs after reset");

    rx_overrides_dir_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && rxOnBit && portDir_q[`RX_PIN] |=> !pinOe[`RX_PIN]
    ) else $error("receive pin driven despite serial use");

    tx_pin_drive_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && txSelect
        |=> pinOe[`TX_PIN] && pinOut[`TX_PIN] == $past(txData)
    ) else $error("transmit pin not driven by serial data");

    rx_pin_input_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && rxOnBit |=> !pinOe[`RX_PIN] ##1 rxData == $past(pinIn[`RX_PIN])
    ) else $error("receive pin not an input");

    sck_out_drive_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && !clockSelectHigh && (clockSelectLow || syncMode)
        |=> pinOe[`SCK_PIN] && pinOut[`SCK_PIN] == $past(sckOut)
    ) else $error("clock pin not driving serial clock");

    sck_in_float_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && clockSelectHigh |=> !pinOe[`SCK_PIN]
    ) else $error("clock pin driven while clock input");

    hold_stable_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_HOLD |=> $stable(pinOe) && $stable(pinOut)
    ) else $error("pins changed in retaining mode");

    standby_hiz_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        powerMode == port2_pkg::PM_STANDBY |=> ##1 pinOe == 8'h00
    ) else $error("pins driven in standby");

    standby_out_low_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        powerMode == port2_pkg::PM_STANDBY |=> ##1 pinOut == 8'h00
    ) else $error("pin data not cleared in standby");

    tx_gpio_follow_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && !txSelect
        |=> pinOe[`TX_PIN] == $past(portDir_q[`TX_PIN])
            && pinOut[`TX_PIN] == $past(portData_q[`TX_PIN])
    ) else $error("transmit pin not general when deselected");

    rx_gpio_follow_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && !rxOnBit
        |=> pinOe[`RX_PIN] == $past(portDir_q[`RX_PIN])
            && pinOut[`RX_PIN] == $past(portData_q[`RX_PIN])
    ) else $error("receive pin not general when disabled");

    sck_gpio_follow_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        portState_q == port2_pkg::ST_RUN && !clockSelectHigh && !clockSelectLow && !syncMode
        |=> pinOe[`SCK_PIN] == $past(portDir_q[`SCK_PIN])
            && pinOut[`SCK_PIN] == $past(portData_q[`SCK_PIN])
    ) else $error("clock pin not general when serial clock off");

endmodule // port2_gpio

//--- verification/port2_board.sv
// Purpose: Board-side model of the eight port 2 pins
// Assumes: Plain wires, no pull resistors on the board
// Notes: An undriven pin shows the level that the board applies
`timescale 1ns/1ps
module port2_board (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] boardLevel,
    output logic [7:0] pinIn
);
    // Device wins where it drives, board elsewhere
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinIn[i] = pinOe[i] ? pinOut[i] : boardLevel[i];
        end
    end
endmodule // port2_board

//--- verification/port2_gpio_bench.sv
// Purpose: Self-checking bench for the port 2 block
// Assumes: Board model resolves every pin level
// Notes: Pin checks wait two edges for state then pins
`timescale 1ns/1ps
`include "port2_defs.svh"
module port2_gpio_bench;
    logic sys_clk, rst_n, regWrite, regRead, rxOnBit, clockSelectHigh, clockSelectLow;
    logic syncMode, txData, sckOut, txSelect, rxData, sckIn;
    logic [15:0] regAddr;
    logic [7:0] regWrData, regRdData, pinIn, pinOut, pinOe, boardLevel;
    port2_pkg::powerMode_t powerMode;
    int errors = 0;
    int checks_done = 0;

    port2_gpio dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .powerMode(powerMode), .rxOnBit(rxOnBit), .clockSelectHigh(clockSelectHigh),
        .clockSelectLow(clockSelectLow), .syncMode(syncMode), .txData(txData),
        .sckOut(sckOut), .txSelect(txSelect), .rxData(rxData), .sckIn(sckIn));
    port2_board board_u (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLevel),
        .pinIn(pinIn));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic complete_run();
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= addr;
        regWrData <= data;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] addr, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check(what, exp, regRdData);
    endtask

    task automatic pin_check(input logic [7:0] expOe, input logic [7:0] expOut);
        repeat (2) @(posedge sys_clk);
        #1;
        check("pinOe", expOe, pinOe);
        check("pinOut", expOut & expOe, pinOut & expOe);
    endtask

    task automatic set_mode(input port2_pkg::powerMode_t m);
        @(posedge sys_clk);
        powerMode <= m;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic reset_values();
        reg_read(`PORT_DATA_ADDR, 8'hA5, "data as inputs");
        reg_read(`PORT_DIR_ADDR, 8'hFF, "direction");
        reg_read(`PIN_MODE_B_ADDR, 8'hF8, "pin mode");
        reg_write(`PORT_DIR_ADDR, 8'hFF);
        reg_read(`PORT_DATA_ADDR, 8'h00, "data reset");
        pin_check(8'hFF, 8'h00);
    endtask

    task automatic gpio_mix();
        reg_write(`PORT_DATA_ADDR, 8'h3C);
        reg_write(`PORT_DIR_ADDR, 8'hF0);
        reg_read(`PORT_DATA_ADDR, 8'h35, "data mixed");
        pin_check(8'hF0, 8'h3C);
        reg_read(`PORT_DIR_ADDR, 8'hFF, "direction");
        reg_write(16'hFFD6, 8'hFF);
        reg_read(16'hFFD6, 8'h00, "unmapped");
        reg_write(`PORT_DIR_ADDR, 8'h0F);
        reg_read(`PORT_DATA_ADDR, 8'hAC, "data swapped");
        pin_check(8'h0F, 8'h3C);
        reg_write(`PORT_DIR_ADDR, 8'h00);
        pin_check(8'h00, 8'h00);
        check("rxData", 8'h00, {7'h00, rxData});
        check("sckIn", 8'h01, {7'h00, sckIn});
    endtask

    task automatic serial_pins();
        logic oe0;
        logic out0;
        reg_write(`PORT_DATA_ADDR, 8'h01);
        reg_write(`PIN_MODE_B_ADDR, 8'h04);
        txData <= 1'b1;
        reg_read(`PIN_MODE_B_ADDR, 8'hFC, "pin mode");
        check("txSelect", 8'h01, {7'h00, txSelect});
        pin_check(8'h04, 8'h04);
        rxOnBit <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            for (int d = 0; d < 2; d++) begin
                @(posedge sys_clk);
                clockSelectHigh <= c[2];
                clockSelectLow <= c[1];
                syncMode <= c[0];
                sckOut <= c[1];
                reg_write(`PORT_DIR_ADDR, d[0] ? 8'h03 : 8'h02);
                oe0 = c[2] ? 1'b0 : ((c[1] | c[0]) ? 1'b1 : d[0]);
                out0 = (c[1] | c[0]) ? sckOut : 1'b1;
                pin_check({5'h00, 2'b10, oe0}, {5'h00, 2'b10, out0});
            end
        end
        @(posedge sys_clk);
        rxOnBit <= 1'b0;
        clockSelectHigh <= 1'b0;
        clockSelectLow <= 1'b0;
        syncMode <= 1'b0;
        reg_write(`PIN_MODE_B_ADDR, 8'hFF);
        reg_read(`PIN_MODE_B_ADDR, 8'hFD, "pin mode masked");
        reg_write(`PIN_MODE_B_ADDR, 8'h00);
        pin_check(8'h03, 8'h01);
    endtask

    task automatic power_modes();
        port2_pkg::powerMode_t holds[3];
        logic [7:0] cur;
        holds = '{port2_pkg::PM_SLEEP, port2_pkg::PM_SUBSLEEP, port2_pkg::PM_WATCH};
        cur = 8'h5A;
        reg_write(`PORT_DIR_ADDR, 8'hFF);
        reg_write(`PORT_DATA_ADDR, cur);
        pin_check(8'hFF, cur);
        foreach (holds[i]) begin
            set_mode(holds[i]);
            pin_check(8'hFF, cur);
            reg_write(`PORT_DATA_ADDR, ~cur);
            pin_check(8'hFF, cur);
            cur = ~cur;
            set_mode(port2_pkg::PM_ACTIVE);
            pin_check(8'hFF, cur);
        end
        set_mode(port2_pkg::PM_STANDBY);
        pin_check(8'h00, 8'h00);
        set_mode(port2_pkg::PM_SUBACTIVE);
        pin_check(8'hFF, cur);
        set_mode(port2_pkg::PM_ACTIVE);
    endtask

    task automatic mid_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("pinOe in reset", 8'h00, pinOe);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_read(`PORT_DATA_ADDR, 8'hA5, "data as inputs");
        check("txSelect", 8'h00, {7'h00, txSelect});
        reg_write(`PORT_DIR_ADDR, 8'hFF);
        reg_read(`PORT_DATA_ADDR, 8'h00, "data reset");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        regAddr = 16'h0000;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        boardLevel = 8'hA5;
        powerMode = port2_pkg::PM_ACTIVE;
        rxOnBit = 1'b0;
        clockSelectHigh = 1'b0;
        clockSelectLow = 1'b0;
        syncMode = 1'b0;
        txData = 1'b0;
        sckOut = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        check("pinOe in reset", 8'h00, pinOe);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        reset_values();
        gpio_mix();
        serial_pins();
        power_modes();
        mid_reset();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        complete_run();
    end
endmodule // port2_gpio_bench
